// [sch_device.sv]
// Behaviour
// - Host writes subcommand, keys, then opcode
// - Completion status at 1F7, error at 1F1
// - Host periodically reads, saves or checks status
// - Subcommand D2h enables (count F1h) or disables (count 00h) periodic attribute autosave
// - Host polls return status, reads cylinders
// - Cylinders C2h/4Fh healthy, 2Ch/F4h failing
// - Value below threshold predicts failure
// - Subcommand D0h sends 512 attribute bytes
// - Subcommand D1h sends 512 threshold bytes
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module sch_device
	import sch_pkg::*;
#(
	parameter int AUTOSAVE_PERIOD = AUTOSAVE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	sch_link_if.dev link,
	input wire logic mem_we,
	input wire logic mem_thr_sel,
	input wire logic [8:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic save_pulse,
	output logic autosave_on,
	output logic fail_predicted
);
	typedef enum logic [3:0] {
		D_IDLE = 4'b0001,
		D_EXEC = 4'b0010,
		D_CHECK = 4'b0100,
		D_SEND = 4'b1000
	} sch_dstate_e;

	typedef struct packed {
		sch_dstate_e state;
		logic [7:0] feature;
		logic [7:0] sect_cnt;
		logic [7:0] sect_num;
		logic [7:0] cyl_low;
		logic [7:0] cyl_high;
		logic [7:0] drv_head;
		logic [7:0] opcode;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] rdata;
		logic [8:0] idx;
		logic thr_sel;
		logic fail_acc;
		logic fail;
		logic autosave;
		logic [31:0] timer;
		logic save;
	} sch_dev_s;

	sch_dev_s st_reg, st_next;
	logic [7:0] attr_mem [BLOCK_BYTES];
	logic [7:0] thr_mem [BLOCK_BYTES];
	logic buf_ready;
	logic [7:0] send_byte;
	logic [7:0] attr_id, attr_val, thr_val;

	// Byte address of one field of attribute number k
	function automatic logic [8:0] attr_addr(input logic [8:0] k, input int ofs);
		attr_addr = 9'(ATTR_BASE + ofs) + 9'(k * 9'(ATTR_STRIDE));
	endfunction

	always_ff @(posedge aclk) begin
		if (mem_we && !mem_thr_sel) begin
			attr_mem[mem_addr] <= mem_wdata;
		end
		if (mem_we && mem_thr_sel) begin
			thr_mem[mem_addr] <= mem_wdata;
		end
	end

	assign send_byte = st_reg.thr_sel ? thr_mem[st_reg.idx] : attr_mem[st_reg.idx];
	assign attr_id = attr_mem[attr_addr(st_reg.idx, ATTR_ID_OFS)];
	assign attr_val = attr_mem[attr_addr(st_reg.idx, ATTR_VAL_OFS)];
	assign thr_val = thr_mem[attr_addr(st_reg.idx, THR_VAL_OFS)];

	// Two entries so a host stall never drops a byte in flight
	sch_buf2 u_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(st_reg.state == D_SEND),
		.in_ready(buf_ready),
		.in_data(send_byte),
		.out_valid(link.dvalid),
		.out_ready(link.dready),
		.out_data(link.dbyte)
	);

	assign link.rdata = st_reg.rdata;
	assign save_pulse = st_reg.save;
	assign autosave_on = st_reg.autosave;
	assign fail_predicted = st_reg.fail;

	always_comb begin
		st_next = st_reg;
		st_next.save = 1'b0;
		// Register writes; the block is locked while the device is busy
		if (link.wr && st_reg.state == D_IDLE) begin
			case (link.addr)
				TF_FEATURE: begin
					st_next.feature = link.wdata;
				end
				TF_SECT_CNT: begin
					st_next.sect_cnt = link.wdata;
				end
				TF_SECT_NUM: begin
					st_next.sect_num = link.wdata;
				end
				TF_CYL_LOW: begin
					st_next.cyl_low = link.wdata;
				end
				TF_CYL_HIGH: begin
					st_next.cyl_high = link.wdata;
				end
				TF_DRV_HEAD: begin
					st_next.drv_head = link.wdata;
				end
				TF_COMMAND: begin
					st_next.opcode = link.wdata;
					st_next.status = 8'h00;
					st_next.status[ST_BSY] = 1'b1;
					st_next.state = D_EXEC;
				end
				default: begin
				end
			endcase
		end
		if (link.rd) begin
			case (link.addr)
				TF_FEATURE: begin
					st_next.rdata = st_reg.error;
				end
				TF_SECT_CNT: begin
					st_next.rdata = st_reg.sect_cnt;
				end
				TF_SECT_NUM: begin
					st_next.rdata = st_reg.sect_num;
				end
				TF_CYL_LOW: begin
					st_next.rdata = st_reg.cyl_low;
				end
				TF_CYL_HIGH: begin
					st_next.rdata = st_reg.cyl_high;
				end
				TF_DRV_HEAD: begin
					st_next.rdata = st_reg.drv_head;
				end
				TF_COMMAND: begin
					st_next.rdata = st_reg.status;
				end
				default: begin
					st_next.rdata = 8'h00;
				end
			endcase
		end
		// Periodic save while autosave is on
		if (st_reg.autosave) begin
			if (st_reg.timer == 32'(AUTOSAVE_PERIOD - 1)) begin
				st_next.timer = 32'h0000_0000;
				st_next.save = 1'b1;
			end else begin
				st_next.timer = st_reg.timer + 32'h0000_0001;
			end
		end else begin
			st_next.timer = 32'h0000_0000;
		end
		case (st_reg.state)
			D_IDLE: begin
			end
			D_EXEC: begin
				st_next.status = ST_RESET;
				st_next.error = 8'h00;
				st_next.state = D_IDLE;
				if (st_reg.opcode != CMD_SMART || st_reg.cyl_low != KEY_CYL_LOW
						|| st_reg.cyl_high != KEY_CYL_HIGH) begin
					st_next.status[ST_ERR] = 1'b1;
					st_next.error = ER_ABORT;
				end else begin
					case (st_reg.feature)
						SUB_READ_ATTR, SUB_READ_THR: begin
							st_next.thr_sel = (st_reg.feature == SUB_READ_THR);
							st_next.idx = 9'h000;
							st_next.status[ST_DRQ] = 1'b1;
							st_next.state = D_SEND;
						end
						SUB_AUTOSAVE: begin
							if (st_reg.sect_cnt == AUTOSAVE_ON) begin
								st_next.autosave = 1'b1;
							end else if (st_reg.sect_cnt == AUTOSAVE_OFF) begin
								st_next.autosave = 1'b0;
							end else begin
								st_next.status[ST_ERR] = 1'b1;
								st_next.error = ER_ABORT;
							end
						end
						SUB_SAVE: begin
							st_next.save = 1'b1;
						end
						SUB_STATUS: begin
							st_next.idx = 9'h000;
							st_next.fail_acc = 1'b0;
							st_next.status = 8'h00;
							st_next.status[ST_BSY] = 1'b1;
							st_next.state = D_CHECK;
						end
						default: begin
							st_next.status[ST_ERR] = 1'b1;
							st_next.error = ER_ABORT;
						end
					endcase
				end
			end
			D_CHECK: begin
				// One attribute per cycle; ID zero marks an unused slot
				if (attr_id != 8'h00 && attr_val < thr_val) begin
					st_next.fail_acc = 1'b1;
				end
				st_next.idx = st_reg.idx + 9'h001;
				if (st_reg.idx == LAST_ATTR) begin
					st_next.fail = st_next.fail_acc;
					st_next.cyl_low = st_next.fail_acc ? FAIL_CYL_LOW : KEY_CYL_LOW;
					st_next.cyl_high = st_next.fail_acc ? FAIL_CYL_HIGH : KEY_CYL_HIGH;
					st_next.status = ST_RESET;
					st_next.state = D_IDLE;
				end
			end
			D_SEND: begin
				if (buf_ready) begin
					st_next.idx = st_reg.idx + 9'h001;
					if (st_reg.idx == LAST_BYTE) begin
						st_next.status = ST_RESET;
						st_next.state = D_IDLE;
					end
				end
			end
			default: begin
				st_next.state = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.state <= D_IDLE;
			st_reg.status <= ST_RESET;
			st_reg.drv_head <= DRV_HEAD_DEF;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

// [sch_pkg.sv]
package sch_pkg;
	// Task-file offsets, as seen on the link address
	localparam logic [11:0] TF_DATA = 12'h01F0;
	localparam logic [11:0] TF_FEATURE = 12'h01F1;
	localparam logic [11:0] TF_SECT_CNT = 12'h01F2;
	localparam logic [11:0] TF_SECT_NUM = 12'h01F3;
	localparam logic [11:0] TF_CYL_LOW = 12'h01F4;
	localparam logic [11:0] TF_CYL_HIGH = 12'h01F5;
	localparam logic [11:0] TF_DRV_HEAD = 12'h01F6;
	localparam logic [11:0] TF_COMMAND = 12'h01F7;
	// Opcode and subcommands
	localparam logic [7:0] CMD_SMART = 8'hB0;
	localparam logic [7:0] SUB_READ_ATTR = 8'hD0;
	localparam logic [7:0] SUB_READ_THR = 8'hD1;
	localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
	localparam logic [7:0] SUB_SAVE = 8'hD3;
	localparam logic [7:0] SUB_STATUS = 8'hDA;
	localparam logic [7:0] AUTOSAVE_ON = 8'hF1;
	localparam logic [7:0] AUTOSAVE_OFF = 8'h00;
	localparam logic [7:0] KEY_CYL_LOW = 8'h4F;
	localparam logic [7:0] KEY_CYL_HIGH = 8'hC2;
	localparam logic [7:0] FAIL_CYL_LOW = 8'hF4;
	localparam logic [7:0] FAIL_CYL_HIGH = 8'h2C;
	localparam logic [7:0] DRV_HEAD_DEF = 8'hA0;
	// Status and error bits
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam logic [7:0] ST_RESET = 8'h40;
	localparam logic [7:0] ER_ABORT = 8'h04;
	// Data block layout
	localparam int BLOCK_BYTES = 512;
	localparam logic [8:0] LAST_BYTE = 9'h1FF;
	localparam int ATTR_BASE = 2;
	localparam int ATTR_STRIDE = 12;
	localparam int ATTR_ID_OFS = 0;
	localparam int ATTR_VAL_OFS = 3;
	localparam int THR_VAL_OFS = 1;
	localparam logic [8:0] LAST_ATTR = 9'h01D;
	// Autosave period
	localparam int CLK_MHZ = 50;
	localparam int AUTOSAVE_MS = 1000;
	localparam int AUTOSAVE_CYCLES = AUTOSAVE_MS * 1000 * CLK_MHZ;
	// Host controller registers on AXI4-Lite
	localparam logic [11:0] AX_CTRL = 12'h000;
	localparam logic [11:0] AX_STATUS = 12'h004;
	localparam logic [11:0] AX_CYL = 12'h008;
	localparam logic [11:0] AX_BLOCK = 12'h200;
	localparam int CTRL_START = 16;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [sch_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sch_link_if;
	logic [11:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic dvalid;
	logic dready;
	logic [7:0] dbyte;
	modport dev (input addr, input wr, input rd, input wdata, output rdata,
		output dvalid, input dready, output dbyte);
	modport host (output addr, output wr, output rd, output wdata, input rdata,
		input dvalid, output dready, input dbyte);
endinterface
`default_nettype wire

// [sch_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
module sch_buf2 (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	typedef struct packed {
		logic [1:0][7:0] slot;
		logic [1:0] count;
	} sch_buf_s;
	sch_buf_s st_reg, st_next;
	logic push, pop;

	assign in_ready = (st_reg.count != 2'd2);
	assign out_valid = (st_reg.count != 2'd0);
	assign out_data = st_reg.slot[0];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (pop) begin
			st_next.slot[0] = st_reg.slot[1];
		end
		if (push) begin
			// Slot index after an optional pop
			if (st_reg.count == 2'd0 || (st_reg.count == 2'd1 && pop)) begin
				st_next.slot[0] = in_data;
			end else begin
				st_next.slot[1] = in_data;
			end
		end
		st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

// [sch_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sch_host
	import sch_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	sch_link_if.host link,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_ISSUE = 5'b00010,
		H_POLL = 5'b00100,
		H_DATA = 5'b01000,
		H_FETCH = 5'b10000
	} sch_hstate_e;

	typedef struct packed {
		sch_hstate_e state;
		logic [2:0] step;
		logic phase;
		logic [7:0] feature;
		logic [7:0] sect_cnt;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] cyl_low;
		logic [7:0] cyl_high;
		logic done;
		logic [8:0] cnt;
		logic [11:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} sch_host_s;

	sch_host_s st_reg, st_next;
	logic [7:0] block [BLOCK_BYTES];
	logic wr_go, rd_go;
	logic [8:0] rbase;

	function automatic logic [11:0] fetch_addr(input logic [2:0] s);
		case (s)
			3'd0: fetch_addr = TF_FEATURE;
			3'd1: fetch_addr = TF_CYL_LOW;
			default: fetch_addr = TF_CYL_HIGH;
		endcase
	endfunction

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
	assign rd_go = s_axi_arvalid && !st_reg.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rdata = st_reg.rdata;
	assign link.addr = st_reg.addr;
	assign link.wr = st_reg.wr;
	assign link.rd = st_reg.rd;
	assign link.wdata = st_reg.wdata;
	assign link.dready = (st_reg.state == H_DATA);
	assign rbase = {s_axi_araddr[8:2], 2'b00};

	always_ff @(posedge aclk) begin
		if (link.dvalid && st_reg.state == H_DATA) begin
			block[st_reg.cnt] <= link.dbyte;
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.wr = 1'b0;
		st_next.rd = 1'b0;
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (wr_go) begin
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_SLVERR;
			if (s_axi_awaddr == AX_CTRL) begin
				st_next.bresp = RESP_OKAY;
				if (s_axi_wstrb[0]) begin
					st_next.feature = s_axi_wdata[7:0];
				end
				if (s_axi_wstrb[1]) begin
					st_next.sect_cnt = s_axi_wdata[15:8];
				end
				// A start while a command runs is dropped
				if (s_axi_wstrb[2] && s_axi_wdata[CTRL_START] && st_reg.state == H_IDLE) begin
					st_next.state = H_ISSUE;
					st_next.step = 3'd0;
					st_next.done = 1'b0;
				end
			end
		end
		if (rd_go) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = 32'h0000_0000;
			if (s_axi_araddr >= AX_BLOCK && s_axi_araddr[1:0] == 2'b00) begin
				st_next.rdata = {block[rbase + 9'd3], block[rbase + 9'd2],
					block[rbase + 9'd1], block[rbase]};
			end else if (s_axi_araddr == AX_STATUS) begin
				st_next.rdata = {8'h00, st_reg.error, st_reg.status, 4'h0,
					(st_reg.cyl_low == FAIL_CYL_LOW && st_reg.cyl_high == FAIL_CYL_HIGH),
					st_reg.status[ST_ERR], st_reg.done, (st_reg.state != H_IDLE)};
			end else if (s_axi_araddr == AX_CYL) begin
				st_next.rdata = {16'h0000, st_reg.cyl_high, st_reg.cyl_low};
			end else if (s_axi_araddr != AX_CTRL) begin
				st_next.rresp = RESP_SLVERR;
			end else begin
				st_next.rdata = {16'h0000, st_reg.sect_cnt, st_reg.feature};
			end
		end
		case (st_reg.state)
			H_IDLE: begin
			end
			H_ISSUE: begin
				// Features, count, keys, drive, then the opcode last
				st_next.wr = 1'b1;
				st_next.step = st_reg.step + 3'd1;
				case (st_reg.step)
					3'd0: begin
						st_next.addr = TF_FEATURE;
						st_next.wdata = st_reg.feature;
					end
					3'd1: begin
						st_next.addr = TF_SECT_CNT;
						st_next.wdata = st_reg.sect_cnt;
					end
					3'd2: begin
						st_next.addr = TF_CYL_LOW;
						st_next.wdata = KEY_CYL_LOW;
					end
					3'd3: begin
						st_next.addr = TF_CYL_HIGH;
						st_next.wdata = KEY_CYL_HIGH;
					end
					3'd4: begin
						st_next.addr = TF_DRV_HEAD;
						st_next.wdata = DRV_HEAD_DEF;
					end
					default: begin
						st_next.addr = TF_COMMAND;
						st_next.wdata = CMD_SMART;
						st_next.state = H_POLL;
						st_next.phase = 1'b0;
					end
				endcase
			end
			H_POLL: begin
				st_next.phase = !st_reg.phase;
				if (!st_reg.phase) begin
					st_next.addr = TF_COMMAND;
					st_next.rd = 1'b1;
				end else if (st_reg.rd) begin
					// Read data lands one cycle after the strobe, so wait for it
					st_next.phase = 1'b1;
				end else if (link.rdata[ST_DRQ]) begin
					st_next.state = H_DATA;
					st_next.cnt = 9'h000;
				end else if (!link.rdata[ST_BSY]) begin
					st_next.status = link.rdata;
					st_next.state = H_FETCH;
					st_next.step = 3'd0;
					st_next.phase = 1'b0;
				end
			end
			H_DATA: begin
				if (link.dvalid) begin
					st_next.cnt = st_reg.cnt + 9'h001;
					if (st_reg.cnt == LAST_BYTE) begin
						st_next.state = H_POLL;
						st_next.phase = 1'b0;
					end
				end
			end
			H_FETCH: begin
				st_next.phase = !st_reg.phase;
				if (!st_reg.phase) begin
					st_next.addr = fetch_addr(st_reg.step);
					st_next.rd = 1'b1;
				end else if (st_reg.rd) begin
					st_next.phase = 1'b1;
				end else begin
					st_next.step = st_reg.step + 3'd1;
					case (st_reg.step)
						3'd0: st_next.error = link.rdata;
						3'd1: st_next.cyl_low = link.rdata;
						default: begin
							st_next.cyl_high = link.rdata;
							st_next.done = 1'b1;
							st_next.state = H_IDLE;
						end
					endcase
				end
			end
			default: begin
				st_next.state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.state <= H_IDLE;
			// Mirror starts at the device's own reset status
			st_reg.status <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

// [sch_link_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sch_link_chk
	import sch_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic dvalid,
	input wire logic dready,
	input wire logic [7:0] dbyte
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [9:0] xfer_reg;
	logic [7:0] st_reg;
	logic rd_reg;
	logic [11:0] addr_reg;
	// Last status byte the host sampled decides which error byte is legal
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xfer_reg <= '0;
			st_reg <= '0;
			rd_reg <= 1'b0;
			addr_reg <= '0;
		end else begin
			rd_reg <= rd;
			addr_reg <= addr;
			if (rd_reg && addr_reg == TF_COMMAND) st_reg <= rdata;
			if (wr && addr == TF_COMMAND) xfer_reg <= '0;
			else if (dvalid && dready) xfer_reg <= xfer_reg + 10'h001;
		end
	end
	sequence s_keys;
		wr && addr == TF_CYL_LOW && wdata == KEY_CYL_LOW ##1
		wr && addr == TF_CYL_HIGH && wdata == KEY_CYL_HIGH;
	endsequence
	sequence s_low(logic [7:0] v);
		rd && addr == TF_CYL_LOW ##1 rdata == v ##2 rd && addr == TF_CYL_HIGH;
	endsequence
	a_cmd_order: assert property (wr && addr == TF_FEATURE |=>
		(wr && addr == TF_SECT_CNT) ##1 s_keys ##1 (wr && addr == TF_DRV_HEAD)
		##1 (wr && addr == TF_COMMAND && wdata == CMD_SMART))
		else $error("command register sequence broken");
	a_wr_window: assert property (wr |-> addr >= TF_FEATURE && addr <= TF_COMMAND)
		else $error("write outside the register file");
	a_block_len: assert property (rd && addr == TF_FEATURE |->
		xfer_reg == 10'h000 || xfer_reg == 10'h200)
		else $error("data block length wrong");
	a_hold_byte: assert property (dvalid && !dready |=> dvalid && $stable(dbyte))
		else $error("stalled data byte changed");
	a_data_quiet: assert property (dvalid |-> !wr)
		else $error("register write during data phase");
	a_cyl_fail: assert property (s_low(FAIL_CYL_LOW) |=> rdata == FAIL_CYL_HIGH)
		else $error("failing cylinder pair mismatched");
	a_cyl_ok: assert property (s_low(KEY_CYL_LOW) |=> rdata == KEY_CYL_HIGH)
		else $error("healthy cylinder pair mismatched");
	a_err_code: assert property (rd && addr == TF_FEATURE |=>
		rdata == (st_reg[ST_ERR] ? ER_ABORT : 8'h00))
		else $error("error byte disagrees with status");
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import sch_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_wvalid = 1'b0;
	logic [11:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic mem_we = 1'b0;
	logic mem_thr_sel = 1'b0;
	logic [8:0] mem_addr = '0;
	logic [7:0] mem_wdata = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic save_pulse, autosave_on, fail_predicted;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int saves = 0;
	always #10 aclk = ~aclk;
	sch_link_if link ();
	sch_device #(.AUTOSAVE_PERIOD(20)) i_sch_device (.aclk(aclk), .aresetn(aresetn),
		.link(link), .mem_we(mem_we), .mem_thr_sel(mem_thr_sel), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .save_pulse(save_pulse), .autosave_on(autosave_on),
		.fail_predicted(fail_predicted));
	// Responses are always accepted, so a ready never has to be released
	sch_host i_sch_host (.aclk(aclk), .aresetn(aresetn), .link(link),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(1'b1));
	sch_link_chk i_sch_link_chk (.aclk(aclk), .aresetn(aresetn), .addr(link.addr),
		.wr(link.wr), .rd(link.rd), .wdata(link.wdata), .rdata(link.rdata),
		.dvalid(link.dvalid), .dready(link.dready), .dbyte(link.dbyte));
	always @(posedge aclk) if (aresetn && save_pulse === 1'b1) saves <= saves + 1;
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Requests move just after a rising edge and hold until ready is seen at one
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// Threshold slots hold zero so no attribute can fall below them
	function automatic logic [7:0] pat(input int s, input int n);
		if (s == 1 && n >= 3 && n < 363 && (n - 3) % 12 == 0) return 8'h00;
		return (s == 1) ? 8'(n) ^ 8'hA5 : 8'(n * 7 + 1);
	endfunction
	task automatic run(input logic [7:0] f, input logic [7:0] c, output logic [31:0] st);
		logic [1:0] r;
		int n;
		axi_wr(AX_CTRL, 32'h0001_0000 | {16'h0000, c, f}, r);
		check("start resp", 32'(r), 32'(RESP_OKAY));
		n = 0;
		do begin
			axi_rd(AX_STATUS, st, r);
			n++;
		end while (!(st[1] === 1'b1 && st[0] === 1'b0) && n < 3000);
		// A poll limit that runs out shows up here as a mismatch
		check("command done", 32'(st[1:0]), 32'h0000_0002);
	endtask
	task automatic load_all();
		mem_we <= 1'b1;
		for (int n = 0; n < 1024; n++) begin
			mem_thr_sel <= n[9];
			mem_addr <= n[8:0];
			mem_wdata <= pat(n / 512, n % 512);
			@(posedge aclk);
		end
		mem_we <= 1'b0;
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(AX_STATUS, d, r);
		check("reset status", 32'(d[23:8]), 32'(ST_RESET));
		axi_rd(12'h100, d, r);
		check("unmapped read", 32'(r), 32'(RESP_SLVERR));
		axi_wr(12'h104, 32'h0000_0000, r);
		check("unmapped write", 32'(r), 32'(RESP_SLVERR));
	endtask
	task automatic t_status(input logic bad);
		logic [31:0] st, d;
		logic [1:0] r;
		run(SUB_STATUS, 8'h00, st);
		axi_rd(AX_CYL, d, r);
		check("cylinders", 32'(d[15:0]), bad ? 32'h0000_2CF4 : 32'h0000_C24F);
		check("fail flag", 32'({st[3], fail_predicted}), 32'({bad, bad}));
		check("status byte", 32'(st[23:8]), 32'(ST_RESET));
	endtask
	task automatic t_blocks();
		logic [31:0] st, d;
		logic [1:0] r;
		for (int s = 0; s < 2; s++) begin
			run(s ? SUB_READ_THR : SUB_READ_ATTR, 8'h00, st);
			for (int w = 0; w < 128; w++) begin
				axi_rd(AX_BLOCK + 12'(4 * w), d, r);
				check("block word", d, {pat(s, 4*w+3), pat(s, 4*w+2), pat(s, 4*w+1), pat(s, 4*w)});
			end
		end
	endtask
	task automatic t_autosave();
		logic [31:0] st;
		int s0;
		run(SUB_AUTOSAVE, AUTOSAVE_ON, st);
		check("autosave on", 32'(autosave_on), 32'h0000_0001);
		s0 = saves;
		repeat (100) @(posedge aclk);
		check("autosave ticks", 32'(saves - s0 >= 4 && saves - s0 <= 6), 32'h0000_0001);
		run(SUB_AUTOSAVE, AUTOSAVE_OFF, st);
		s0 = saves;
		repeat (100) @(posedge aclk);
		check("autosave idle", 32'(saves - s0), 32'h0000_0000);
		run(SUB_SAVE, 8'h00, st);
		check("manual save", 32'(saves - s0), 32'h0000_0001);
	endtask
	task automatic t_abort();
		logic [31:0] st, d;
		logic [1:0] r;
		logic [7:0] bad [2] = '{8'hC0, SUB_AUTOSAVE};
		for (int i = 0; i < 2; i++) begin
			run(bad[i], 8'h33, st);
			check("abort bytes", 32'(st[23:8]), 32'({ER_ABORT, ST_RESET | 8'h01}));
			check("abort flag", 32'(st[2]), 32'h0000_0001);
		end
		axi_rd(AX_CTRL, d, r);
		check("ctrl readback", d, {16'h0000, 8'h33, SUB_AUTOSAVE});
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		load_all();
		t_reset();
		t_status(1'b0);
		t_blocks();
		mem_we <= 1'b1;
		mem_thr_sel <= 1'b1;
		mem_addr <= 9'h003;
		mem_wdata <= 8'hFF;
		@(posedge aclk);
		mem_we <= 1'b0;
		t_status(1'b1);
		t_autosave();
		t_abort();
		summarize();
	end
endmodule
`default_nettype wire
